// ===== include/crmp_pkg.sv
`default_nettype none
// ==========================================================
// Shared constants and carriers of the configuration port
package crmp_pkg;

	// ==========================================================
	// Token values
	localparam logic [7:0]  TOK_WR      = 8'hc0;
	localparam logic [7:0]  TOK_RD      = 8'hc1;
	localparam logic [7:0]  TOK_END     = 8'h01;
	localparam logic [7:0]  TOK_ACK     = 8'h03;
	localparam logic [7:0]  TOK_NAK     = 8'h04;

	// ==========================================================
	// Addressing and field layout
	localparam logic [15:0] SUF_TILE    = 16'hc20c;
	localparam logic [15:0] SUF_NODE    = 16'hc30c;
	localparam logic [7:0]  PS_RES_TAG  = 8'h0c;
	localparam int          PS_REG_LSB  = 8;
	localparam logic [7:0]  NO_REPLY    = 8'hff;
	localparam logic [1:0]  RET_LAST    = 2'h2;
	localparam logic [1:0]  REG_LAST    = 2'h1;
	localparam logic [1:0]  DATA_LAST   = 2'h3;
	localparam logic [2:0]  RD_OK_LAST  = 3'h5;
	localparam logic [2:0]  SHORT_LAST  = 3'h1;
	localparam logic [31:0] REG_RST_VAL = 32'h0000_0000;

	// ==========================================================
	// Parser states, Gray along the usual path
	typedef enum logic [2:0] {
		S_IDLE  = 3'b000,
		S_RET   = 3'b001,
		S_REG   = 3'b011,
		S_DATA  = 3'b010,
		S_END   = 3'b110,
		S_REPLY = 3'b111,
		S_SKIP  = 3'b101
	} crmp_state_t;

	// One token on the interconnect: control flag and byte
	typedef struct packed {
		logic       ctrl;
		logic [7:0] data;
	} crmp_tok_t;

endpackage
`default_nettype wire

// ===== design/crmp_port.sv
// Functional notes
// - Return id is node id then channel
// - Write with low byte all ones: no reply
// - Multi-byte fields travel most significant byte first
// - Status resource is register shl 8 or 0x0C
// - Tile endpoint: tile id above suffix C20C
// - Node endpoint: node id above suffix C30C
// - Write reply: 3,1 on success; 4,1 failure
// - Read reply: 3, value, 1; or 4,1
`default_nettype none
module crmp_port import crmp_pkg::*; #(
	parameter int          N_REGS  = 16,
	parameter logic [15:0] TILE_ID = 16'h0000,
	parameter logic [15:0] NODE_ID = 16'h0001
) (
	// Clock and reset
	input  wire logic        CLOCK,
	input  wire logic        RST,
	// Incoming token stream
	input  wire logic        IN_VALID,
	input  wire crmp_tok_t   IN_TOK,
	input  wire logic [31:0] IN_DEST,
	output var  logic        IN_READY,
	// Reply token stream
	output var  logic        OUT_VALID,
	output var  crmp_tok_t   OUT_TOK,
	output var  logic [23:0] OUT_DEST,
	input  wire logic        OUT_READY,
	// Processor status access
	input  wire logic        PS_REQ,
	input  wire logic        PS_WRITE,
	input  wire logic [31:0] PS_RESOURCE,
	input  wire logic [31:0] PS_WDATA,
	output var  logic        PS_ACK,
	output var  logic        PS_ERR,
	output var  logic [31:0] PS_RDATA
);
	localparam int IW = $clog2(N_REGS);

	// ==========================================================
	// Elaboration check: register numbers are compared at 16 bits
	if (N_REGS < 2 || N_REGS > 65535) begin : g_chk
		$error("crmp_port: N_REGS must lie in 2..65535");
	end

	// ==========================================================
	// State
	typedef struct packed {
		crmp_state_t                   st;
		logic [1:0]                    cnt;
		logic [2:0]                    rcnt;
		logic                          is_wr;
		logic                          bad;
		logic                          hit;
		logic                          node;
		logic                          ok;
		logic [23:0]                   ret;
		logic [15:0]                   regn;
		logic [31:0]                   wdat;
		logic [31:0]                   rd;
		logic                          in_rdy;
		logic                          out_vld;
		crmp_tok_t                     out;
		logic                          ps_ack;
		logic                          ps_err;
		logic [31:0]                   ps_rdata;
		logic [N_REGS-1:0][31:0]       tile_regs;
		logic [N_REGS-1:0][31:0]       node_regs;
		logic [N_REGS-1:0][31:0]       ps_regs;
	} crmp_reg_t;

	crmp_reg_t s_r;
	crmp_reg_t s_nxt;
	logic          acc, issue, fin, fin_ok, is_end, last, ps_bad;
	logic [IW-1:0] idx;
	logic [IW-1:0] ps_idx;

	assign acc    = IN_VALID && s_r.in_rdy;
	assign issue  = (s_r.st == S_REPLY) && (!s_r.out_vld || OUT_READY);
	assign is_end = IN_TOK.ctrl && (IN_TOK.data == TOK_END);
	assign idx    = s_r.regn[IW-1:0];
	assign ps_idx = PS_RESOURCE[PS_REG_LSB +: IW];
	// Resource tag and range both checked; unknown resources answer error
	assign ps_bad = (PS_RESOURCE[7:0] != PS_RES_TAG) ||
		(PS_RESOURCE[31:PS_REG_LSB] >= 24'(N_REGS));

	// ==========================================================
	// Next-state logic
	always_comb begin
		s_nxt  = s_r;
		fin    = 1'b0;
		fin_ok = 1'b0;
		last   = 1'b0;
		// A held token leaves once the far side takes it
		if (s_r.out_vld && OUT_READY) begin
			s_nxt.out_vld = 1'b0;
		end
		case (s_r.st)
			S_IDLE: if (acc && !is_end) begin
				// Leading token picks the message shape
				s_nxt.st    = S_RET;
				s_nxt.cnt   = 2'h0;
				s_nxt.is_wr = IN_TOK.data == TOK_WR;
				s_nxt.bad   = !IN_TOK.ctrl ||
					(IN_TOK.data != TOK_WR && IN_TOK.data != TOK_RD);
				s_nxt.node  = IN_DEST[15:0] == SUF_NODE;
				s_nxt.hit   = (IN_DEST[15:0] == SUF_TILE &&
					IN_DEST[31:16] == TILE_ID) ||
					(IN_DEST[15:0] == SUF_NODE &&
					IN_DEST[31:16] == NODE_ID);
			end
			S_RET: if (acc) begin
				// Without a whole return id nobody can be answered
				if (IN_TOK.ctrl) begin
					s_nxt.st = S_IDLE;
				end else begin
					s_nxt.ret = {s_r.ret[15:0], IN_TOK.data};
					s_nxt.cnt = s_r.cnt + 2'h1;
					if (s_r.cnt == RET_LAST) begin
						s_nxt.cnt = 2'h0;
						s_nxt.st  = s_r.bad ? S_SKIP : S_REG;
					end
				end
			end
			S_REG, S_DATA: if (acc) begin
				if (IN_TOK.ctrl) begin
					// Early token: truncated message
					s_nxt.bad = 1'b1;
					fin       = is_end;
					s_nxt.st  = S_SKIP;
				end else if (s_r.st == S_REG) begin
					s_nxt.regn = {s_r.regn[7:0], IN_TOK.data};
					s_nxt.cnt  = s_r.cnt + 2'h1;
					if (s_r.cnt == REG_LAST) begin
						s_nxt.cnt = 2'h0;
						s_nxt.st  = s_r.is_wr ? S_DATA : S_END;
					end
				end else begin
					s_nxt.wdat = {s_r.wdat[23:0], IN_TOK.data};
					s_nxt.cnt  = s_r.cnt + 2'h1;
					if (s_r.cnt == DATA_LAST) begin
						s_nxt.st = S_END;
					end
				end
			end
			S_END: if (acc) begin
				// Anything but the closing token overruns the message
				fin      = is_end;
				fin_ok   = is_end && s_r.regn < 16'(N_REGS);
				s_nxt.st = S_SKIP;
				if (!is_end) begin
					s_nxt.bad = 1'b1;
				end
			end
			S_SKIP: if (acc) begin
				fin = is_end;
			end
			S_REPLY: if (issue) begin
				// Success read carries four data bytes between tokens
				last = (s_r.ok && !s_r.is_wr) ? s_r.rcnt == RD_OK_LAST
					: s_r.rcnt == SHORT_LAST;
				s_nxt.out_vld = 1'b1;
				s_nxt.rcnt    = s_r.rcnt + 3'h1;
				if (s_r.rcnt == 3'h0) begin
					s_nxt.out = '{1'b1, s_r.ok ? TOK_ACK : TOK_NAK};
				end else if (last) begin
					s_nxt.out = '{1'b1, TOK_END};
					s_nxt.st  = S_IDLE;
				end else begin
					s_nxt.out = '{1'b0, s_r.rd[31:24]};
					s_nxt.rd  = {s_r.rd[23:0], 8'h00};
				end
			end
			default: s_nxt.st = S_IDLE;
		endcase
		// Close of message: commit, then decide whether to answer
		if (fin) begin
			s_nxt.ok   = fin_ok;
			s_nxt.rcnt = 3'h0;
			s_nxt.rd   = s_r.node ? s_r.node_regs[idx] : s_r.tile_regs[idx];
			s_nxt.st   = S_REPLY;
			if (fin_ok && s_r.is_wr && s_r.hit) begin
				if (s_r.node) begin
					s_nxt.node_regs[idx] = s_r.wdat;
				end else begin
					s_nxt.tile_regs[idx] = s_r.wdat;
				end
			end
			// Foreign destinations and silent writes get no answer
			if (!s_r.hit || (s_r.is_wr && s_r.ret[7:0] == NO_REPLY)) begin
				s_nxt.st = S_IDLE;
			end
		end
		// Status registers answer in the cycle after the request
		s_nxt.ps_ack = PS_REQ;
		s_nxt.ps_err = PS_REQ && ps_bad;
		if (PS_REQ && !ps_bad) begin
			s_nxt.ps_rdata = s_r.ps_regs[ps_idx];
			if (PS_WRITE) begin
				s_nxt.ps_regs[ps_idx] = PS_WDATA;
			end
		end
		// Input stalls while a reply is being sent
		s_nxt.in_rdy = s_nxt.st != S_REPLY;
	end

	// ==========================================================
	// State register
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			s_r           <= '0;
			s_r.st        <= S_IDLE;
			s_r.tile_regs <= {N_REGS{REG_RST_VAL}};
			s_r.node_regs <= {N_REGS{REG_RST_VAL}};
			s_r.ps_regs   <= {N_REGS{REG_RST_VAL}};
		end else begin
			s_r <= s_nxt;
		end
	end

	// Outputs straight from the state register
	assign IN_READY  = s_r.in_rdy;
	assign OUT_VALID = s_r.out_vld;
	assign OUT_TOK   = s_r.out;
	assign OUT_DEST  = s_r.ret;
	assign PS_ACK    = s_r.ps_ack;
	assign PS_ERR    = s_r.ps_err;
	assign PS_RDATA  = s_r.ps_rdata;

	// ==========================================================
	// Checks
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (RST);

	sequence s_issue;
		s_r.st == S_REPLY && (!s_r.out_vld || OUT_READY);
	endsequence

	property p_out_hold;
		OUT_VALID && !OUT_READY |=> OUT_VALID && $stable(OUT_TOK);
	endproperty
	a_out_hold: assert property (p_out_hold)
		else $error("reply token dropped before taken");

	property p_first_tok;
		s_issue and s_r.rcnt == 3'h0 |=> OUT_TOK.ctrl &&
			OUT_TOK.data == (s_r.ok ? TOK_ACK : TOK_NAK);
	endproperty
	a_first_tok: assert property (p_first_tok)
		else $error("reply does not open with 3 or 4");

	property p_silent_write;
		fin && s_r.is_wr && s_r.ret[7:0] == NO_REPLY |=>
			s_r.st != S_REPLY [*2];
	endproperty
	a_silent_write: assert property (p_silent_write)
		else $error("reply started for a silent write");

	property p_read_data;
		s_issue and s_r.ok && !s_r.is_wr && s_r.rcnt inside {[1:4]}
			|=> !OUT_TOK.ctrl;
	endproperty
	a_read_data: assert property (p_read_data)
		else $error("read value byte sent as control");

	property p_short_end;
		s_issue and !(s_r.ok && !s_r.is_wr) && s_r.rcnt == 3'h1
			|=> OUT_TOK.ctrl && OUT_TOK.data == TOK_END
			##1 s_r.st != S_REPLY;
	endproperty
	a_short_end: assert property (p_short_end)
		else $error("two-token reply not closed by 1");

	property p_msb_first;
		s_r.st == S_RET && acc && !IN_TOK.ctrl |=>
			s_r.ret[7:0] == $past(IN_TOK.data);
	endproperty
	a_msb_first: assert property (p_msb_first)
		else $error("return id not shifted most significant first");

	property p_ps_tag;
		PS_REQ && PS_RESOURCE[7:0] != PS_RES_TAG |=> PS_ACK && PS_ERR;
	endproperty
	a_ps_tag: assert property (p_ps_tag)
		else $error("bad status resource not refused");

	property p_bad_keeps;
		fin && !fin_ok |=> $stable(s_r.tile_regs) &&
			$stable(s_r.node_regs);
	endproperty
	a_bad_keeps: assert property (p_bad_keeps)
		else $error("failed message changed a register");

endmodule // crmp_port
`default_nettype wire

// ===== test/crmp_req_model.sv
`default_nettype none
// ==========================================================
// Requester on the interconnect: sends framed messages, collects replies
module crmp_req_model import crmp_pkg::*; (
	// Clock
	input  wire logic      CLOCK,
	// Request stream towards the port
	output var  logic      in_valid,
	output var  crmp_tok_t in_tok,
	output var  logic [31:0] in_dest,
	input  wire logic      in_ready,
	// Reply stream from the port
	input  wire logic      out_valid,
	input  wire crmp_tok_t out_tok,
	output var  logic      out_ready
);
	crmp_tok_t rx_q[$];
	logic      slow;

	initial begin
		in_valid = 1'b0;
		in_tok = '0;
		in_dest = '0;
		out_ready = 1'b0;
		slow = 1'b0;
	end

	function automatic crmp_tok_t tk(input logic c, input logic [7:0] d);
		return {c, d};
	endfunction

	// Whole message, fields MSB first; nd data bytes (0 cuts a write short)
	task automatic send(input logic [7:0] lead, input logic [31:0] dest,
		input logic [23:0] ret, input logic [15:0] regn,
		input logic [31:0] data, input int nd);
		crmp_tok_t q[$];
		q.push_back(tk(1'b1, lead));
		for (int i = 2; i >= 0; i--)
			q.push_back(tk(1'b0, ret[i*8 +: 8]));
		for (int i = 1; i >= 0; i--)
			q.push_back(tk(1'b0, regn[i*8 +: 8]));
		for (int i = 3; i > 3 - nd; i--)
			q.push_back(tk(1'b0, data[i*8 +: 8]));
		q.push_back(tk(1'b1, TOK_END));
		@(posedge CLOCK);
		foreach (q[i]) begin
			in_valid <= 1'b1;
			in_tok <= q[i];
			in_dest <= dest;
			@(posedge CLOCK);
			while (!in_ready) @(posedge CLOCK);
		end
		// Released lines must not keep showing the last token
		in_valid <= 1'b0;
		in_tok <= ~q[q.size()-1];
		in_dest <= ~dest;
	endtask

	// Take replies; in slow mode ready toggles to stall the port
	always @(posedge CLOCK) begin
		if (out_valid && out_ready) rx_q.push_back(out_tok);
		out_ready <= slow ? ~out_ready : 1'b1;
	end
endmodule // crmp_req_model
`default_nettype wire

// ===== test/tb_config_register_message_port.sv
`default_nettype none
module tb_config_register_message_port import crmp_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [31:0] D_TILE = {16'h0000, SUF_TILE};
	localparam logic [31:0] D_NODE = {16'h0001, SUF_NODE};
	localparam logic [23:0] RET = 24'h010205;
	logic CLOCK = 1'b0, RST = 1'b1;
	logic in_valid, in_ready, out_valid, out_ready;
	crmp_tok_t in_tok, out_tok;
	logic [31:0] in_dest, ps_resource, ps_wdata, ps_rdata;
	logic [23:0] out_dest;
	logic ps_req = 1'b0, ps_write = 1'b0, ps_ack, ps_err;
	int fails = 0, checks_done = 0, cycles = 0;

	always #5 CLOCK = ~CLOCK;
	initial begin
		ps_resource = '0;
		ps_wdata = '0;
	end

	crmp_port #(.N_REGS(16), .TILE_ID(16'h0000), .NODE_ID(16'h0001))
	crmp_port_inst (.CLOCK(CLOCK), .RST(RST), .IN_VALID(in_valid),
		.IN_TOK(in_tok), .IN_DEST(in_dest), .IN_READY(in_ready),
		.OUT_VALID(out_valid), .OUT_TOK(out_tok), .OUT_DEST(out_dest),
		.OUT_READY(out_ready), .PS_REQ(ps_req), .PS_WRITE(ps_write),
		.PS_RESOURCE(ps_resource), .PS_WDATA(ps_wdata), .PS_ACK(ps_ack),
		.PS_ERR(ps_err), .PS_RDATA(ps_rdata));
	crmp_req_model crmp_req_model_inst (.CLOCK(CLOCK), .in_valid(in_valid),
		.in_tok(in_tok), .in_dest(in_dest), .in_ready(in_ready),
		.out_valid(out_valid), .out_tok(out_tok), .out_ready(out_ready));

	task automatic conclude();
		$display("checks %0d fails %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Kind 0 write ok, 1 read ok with data, 2 failure, 3 no reply
	task automatic reply(input logic [31:0] d, input int kind);
		crmp_tok_t e[$];
		int n;
		n = 0;
		if (kind == 2) e.push_back({1'b1, TOK_NAK});
		else if (kind < 3) e.push_back({1'b1, TOK_ACK});
		if (kind == 1) for (int i = 3; i >= 0; i--) e.push_back({1'b0, d[i*8 +: 8]});
		if (kind < 3) e.push_back({1'b1, TOK_END});
		while (crmp_req_model_inst.rx_q.size() < e.size() && n < 200) begin
			@(posedge CLOCK);
			n++;
		end
		// Extra settling catches tokens beyond the expected frame
		repeat (20) @(posedge CLOCK);
		chk("reply count", e.size(), crmp_req_model_inst.rx_q.size());
		foreach (e[i]) if (i < crmp_req_model_inst.rx_q.size())
			chk("reply token", e[i], crmp_req_model_inst.rx_q[i]);
		if (kind < 3) chk("reply dest", RET, out_dest);
		crmp_req_model_inst.rx_q.delete();
	endtask

	task automatic ps(input logic wr, input logic [7:0] rn, input logic [7:0] tag,
		input logic [31:0] wd, input logic err, input logic [31:0] rd);
		@(posedge CLOCK);
		ps_req <= 1'b1;
		ps_write <= wr;
		ps_resource <= (32'(rn) << PS_REG_LSB) | 32'(tag);
		ps_wdata <= wd;
		@(posedge CLOCK);
		ps_req <= 1'b0;
		#1;
		chk("status ack", 32'h1, 32'(ps_ack));
		chk("status err", 32'(err), 32'(ps_err));
		if (!err && !wr) chk("status data", rd, ps_rdata);
	endtask

	task automatic t_tile();
		crmp_req_model_inst.send(TOK_WR, D_TILE, RET, 16'h0003, 32'h12345678, 4);
		reply(32'h0, 0);
		crmp_req_model_inst.send(TOK_RD, D_TILE, RET, 16'h0003, 32'h0, 0);
		reply(32'h12345678, 1);
	endtask

	// Top register, reply path stalled
	task automatic t_node();
		crmp_req_model_inst.slow = 1'b1;
		crmp_req_model_inst.send(TOK_WR, D_NODE, RET, 16'h000f, 32'ha5c30f96, 4);
		reply(32'h0, 0);
		crmp_req_model_inst.send(TOK_RD, D_NODE, RET, 16'h000f, 32'h0, 0);
		reply(32'ha5c30f96, 1);
		crmp_req_model_inst.slow = 1'b0;
	endtask

	task automatic t_silent();
		crmp_req_model_inst.send(TOK_WR, D_NODE, {RET[23:8], NO_REPLY}, 16'h0002,
			32'hdeadbeef, 4);
		reply(32'h0, 3);
		crmp_req_model_inst.send(TOK_RD, D_NODE, RET, 16'h0002, 32'h0, 0);
		reply(32'hdeadbeef, 1);
	endtask

	// Refused and foreign messages must leave the tile and node registers as written
	task automatic t_bad();
		crmp_req_model_inst.send(TOK_WR, D_TILE, RET, 16'h0010, 32'h1, 4);
		reply(32'h0, 2);
		crmp_req_model_inst.send(8'h55, D_TILE, RET, 16'h0003, 32'h2, 4);
		reply(32'h0, 2);
		crmp_req_model_inst.send(TOK_WR, D_TILE, RET, 16'h0003, 32'h3, 0);
		reply(32'h0, 2);
		crmp_req_model_inst.send(TOK_RD, D_TILE, RET, 16'h0010, 32'h0, 0);
		reply(32'h0, 2);
		crmp_req_model_inst.send(TOK_RD, {16'h0007, SUF_TILE}, RET, 16'h3, 32'h0, 0);
		reply(32'h0, 3);
		crmp_req_model_inst.send(TOK_RD, D_TILE, RET, 16'h0003, 32'h0, 1);
		reply(32'h0, 2);
		crmp_req_model_inst.send(TOK_WR, {16'h0002, SUF_NODE}, RET, 16'h000f,
			32'h0, 4);
		reply(32'h0, 3);
		crmp_req_model_inst.send(TOK_RD, D_NODE, RET, 16'h000f, 32'h0, 0);
		reply(32'ha5c30f96, 1);
		crmp_req_model_inst.send(TOK_RD, D_TILE, RET, 16'h0000, 32'h0, 0);
		reply(REG_RST_VAL, 1);
		crmp_req_model_inst.send(TOK_RD, D_TILE, RET, 16'h0003, 32'h0, 0);
		reply(32'h12345678, 1);
	endtask

	task automatic t_ps();
		ps(1'b1, 8'h02, PS_RES_TAG, 32'hcafe0123, 1'b0, 32'h0);
		ps(1'b0, 8'h02, PS_RES_TAG, 32'h0, 1'b0, 32'hcafe0123);
		ps(1'b0, 8'h02, 8'h0d, 32'h0, 1'b1, 32'h0);
		ps(1'b1, 8'h10, PS_RES_TAG, 32'h5, 1'b1, 32'h0);
		ps(1'b0, 8'h00, PS_RES_TAG, 32'h0, 1'b0, REG_RST_VAL);
	endtask

	// Hang guard, well above the several hundred cycles the run needs
	always @(posedge CLOCK) begin
		cycles++;
		if (cycles == 20000) begin
			fails++;
			conclude();
		end
	end

	initial begin
		repeat (4) @(posedge CLOCK);
		RST <= 1'b0;
		repeat (2) @(posedge CLOCK);
		t_tile();
		t_node();
		t_silent();
		t_bad();
		t_ps();
		conclude();
	end
endmodule // tb_config_register_message_port
`default_nettype wire
